// *** hdl/sdc_pkg.sv ***
// Function
// - first falling clock after select samples bit
// - select 01 red, 10 green, 11 blue, 00 test
// - next five bits shift into selected register
// - word is write, select, delay msb first
// - delay equals code times two nanoseconds
// - after eight bits a new word starts
// - bits shift straight into destination register
// - short word leaves register partially shifted
// - all registers clear to zero at reset
// - select falling restarts count; frame each word
// - test word: zeros, slice code, mode bit
// - slice code two's complement, 50 mV steps
// - test mode: green slice, red/blue self delay
// - normal mode: outputs pulse on channel overlap
// - pulse positive if first leads, negative if second leads, none on a tie
package sdc_pkg;

  // ****************************************************
  // word layout and register selects
  // ****************************************************
  localparam int          WORD_BITS    = 8;
  localparam int          CNT_W        = 3;
  localparam int          PAYLOAD_W    = 5;
  localparam int          SLICE_W      = 4;
  localparam logic [2:0]  POS_WRITE    = 3'h0;
  localparam logic [2:0]  POS_SEL_HI   = 3'h1;
  localparam logic [2:0]  POS_SEL_LO   = 3'h2;
  localparam logic [2:0]  POS_LAST     = 3'h7;
  localparam logic        WRITE_VALUE  = 1'h0;
  localparam logic [1:0]  SEL_TEST     = 2'h0;
  localparam logic [1:0]  SEL_RED      = 2'h1;
  localparam logic [1:0]  SEL_GREEN    = 2'h2;
  localparam logic [1:0]  SEL_BLUE     = 2'h3;
  localparam int          NUM_REGS     = 4;
  localparam int          NUM_CH       = 3;
  localparam logic [4:0]  REG_RESET    = 5'h00;
  localparam int          TEST_MODE_BIT = 0;
  localparam int          SLICE_LSB    = 1;

  // ****************************************************
  // scaling and timing
  // ****************************************************
  localparam int          DELAY_STEP_NS = 2;
  localparam int          DELAY_NS_W    = 6;
  localparam int          SLICE_STEP_MV = 50;
  localparam int          SLICE_MV_W    = 10;
  localparam int          SCLK_MAX_MHZ  = 10;
  localparam int          CLK_MHZ       = 200;
  localparam int          SYNC_W        = 9;
  localparam logic [8:0]  SYNC_RESET    = 9'h004;

  // ****************************************************
  // serial state machine
  // ****************************************************
  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'b01,
    ST_ACTIVE = 2'b10
  } sdc_state_type;

endpackage

// *** hdl/sdc_pair_if.sv ***
`timescale 1ns/1ps
// pair of sliced signals in, signed overlap pulse out
interface sdc_pair_if;
  logic a;
  logic b;
  logic pos;
  logic neg;
  modport det
  (
    input  a,
    input  b,
    output pos,
    output neg
  );
  modport user
  (
    output a,
    output b,
    input  pos,
    input  neg
  );
endinterface

// *** hdl/sdc_overlap_det.sv ***
`timescale 1ns/1ps
module sdc_overlap_det
  import sdc_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  sdc_pair_if.det   pair
);

  logic a_prev_r;
  logic a_prev_nxt;
  logic b_prev_r;
  logic b_prev_nxt;
  logic lead_a_r;
  logic lead_a_nxt;
  logic lead_b_r;
  logic lead_b_nxt;
  logic pos_r;
  logic pos_nxt;
  logic neg_r;
  logic neg_nxt;

  // ****************************************************
  // leader tracking and overlap pulse
  // ****************************************************
  // note which signal rose first; clear when both are low
  always_comb
  begin
    a_prev_nxt = pair.a;
    b_prev_nxt = pair.b;
    lead_a_nxt = lead_a_r;
    lead_b_nxt = lead_b_r;
    if (!pair.a && !pair.b)
    begin
      lead_a_nxt = 1'b0;
      lead_b_nxt = 1'b0;
    end
    else
    begin
      // each new rise decides the leader afresh; a tie names none
      if (pair.a && !a_prev_r && !(pair.b && !b_prev_r))
      begin
        lead_a_nxt = !pair.b;
        lead_b_nxt = pair.b;
      end
      else if (pair.b && !b_prev_r && !(pair.a && !a_prev_r))
      begin
        lead_b_nxt = !pair.a;
        lead_a_nxt = pair.a;
      end
      else if (pair.a && !a_prev_r && pair.b && !b_prev_r)
      begin
        lead_a_nxt = 1'b0;
        lead_b_nxt = 1'b0;
      end
    end
    pos_nxt = pair.a && pair.b && lead_a_nxt;
    neg_nxt = pair.a && pair.b && lead_b_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      a_prev_r <= 1'b0;
      b_prev_r <= 1'b0;
      lead_a_r <= 1'b0;
      lead_b_r <= 1'b0;
      pos_r    <= 1'b0;
      neg_r    <= 1'b0;
    end
    else if (ce)
    begin
      a_prev_r <= a_prev_nxt;
      b_prev_r <= b_prev_nxt;
      lead_a_r <= lead_a_nxt;
      lead_b_r <= lead_b_nxt;
      pos_r    <= pos_nxt;
      neg_r    <= neg_nxt;
    end
  end

  assign pair.pos = pos_r;
  assign pair.neg = neg_r;

endmodule

// *** hdl/sdc_config_port.sv ***
`timescale 1ns/1ps
module sdc_config_port
  import sdc_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         srst,
  input  wire logic                         ce,
  input  wire logic                         frame_select_n,
  input  wire logic                         serial_clock,
  input  wire logic                         serial_data,
  input  wire logic [NUM_CH-1:0]            slice_in,
  input  wire logic [NUM_CH-1:0]            slice_out,
  output logic [PAYLOAD_W-1:0]              red_delay_code,
  output logic [PAYLOAD_W-1:0]              green_delay_code,
  output logic [PAYLOAD_W-1:0]              blue_delay_code,
  output logic [DELAY_NS_W-1:0]             red_delay_ns,
  output logic [DELAY_NS_W-1:0]             green_delay_ns,
  output logic [DELAY_NS_W-1:0]             blue_delay_ns,
  output logic [SLICE_W-1:0]                slice_code,
  output logic signed [SLICE_MV_W-1:0]      slice_mv,
  output logic                              test_mode,
  output logic                              green_shows_slice,
  output logic [NUM_CH-1:0]                 test_pulse_pos,
  output logic [NUM_CH-1:0]                 test_pulse_neg
);

  // ****************************************************
  // pin synchronisers
  // ****************************************************
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [SYNC_W-1:0] sync_nxt;
  logic              sclk_s;
  logic              sdata_s;
  logic              frame_n_s;
  logic [NUM_CH-1:0] in_s;
  logic [NUM_CH-1:0] out_s;

  // bit 2 is frame select, reset high so no frame is seen
  always_comb
  begin
    sync_nxt = {slice_out, slice_in, frame_select_n, serial_data,
                serial_clock};
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sync1_r <= SYNC_RESET;
      sync2_r <= SYNC_RESET;
    end
    else if (ce)
    begin
      sync1_r <= sync_nxt;
      sync2_r <= sync1_r;
    end
  end

  assign sclk_s    = sync2_r[0];
  assign sdata_s   = sync2_r[1];
  assign frame_n_s = sync2_r[2];
  assign in_s      = sync2_r[5:3];
  assign out_s     = sync2_r[8:6];

  // ****************************************************
  // serial word decoder
  // ****************************************************
  sdc_state_type          state_r;
  sdc_state_type          state_nxt;
  logic                   sclk_prev_r;
  logic                   sclk_prev_nxt;
  logic [CNT_W-1:0]       cnt_r;
  logic [CNT_W-1:0]       cnt_nxt;
  logic                   wr_n_r;
  logic                   wr_n_nxt;
  logic [1:0]             sel_r;
  logic [1:0]             sel_nxt;
  logic [PAYLOAD_W-1:0]   regs_r   [NUM_REGS];
  logic [PAYLOAD_W-1:0]   regs_nxt [NUM_REGS];
  logic                   sclk_fall;
  logic [CNT_W-1:0]       cnt_eff;

  assign sclk_fall = sclk_prev_r && !sclk_s;

  // count bits on falling serial clock while selected
  always_comb
  begin
    state_nxt     = state_r;
    sclk_prev_nxt = sclk_s;
    cnt_nxt       = cnt_r;
    wr_n_nxt      = wr_n_r;
    sel_nxt       = sel_r;
    cnt_eff       = cnt_r;
    regs_nxt      = regs_r;
    case (state_r)
      ST_IDLE:
      begin
        cnt_eff = '0;
        cnt_nxt = '0;
        if (!frame_n_s)
          state_nxt = ST_ACTIVE;
      end
      ST_ACTIVE:
      begin
        if (frame_n_s)
          state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
        cnt_nxt   = '0;
      end
    endcase
    if (!frame_n_s && sclk_fall && state_r != ST_ACTIVE && state_r != ST_IDLE)
      cnt_eff = '0;
    if (!frame_n_s && sclk_fall)
    begin
      case (cnt_eff)
        POS_WRITE:  wr_n_nxt = (sdata_s != WRITE_VALUE);
        POS_SEL_HI: sel_nxt  = {sdata_s, sel_r[0]};
        POS_SEL_LO: sel_nxt  = {sel_r[1], sdata_s};
        default:
        begin
          // payload goes straight into the live register, msb first
          if (!wr_n_r)
            regs_nxt[sel_r] = {regs_r[sel_r][PAYLOAD_W-2:0],
                               sdata_s};
        end
      endcase
      // wrap to a new word after the eighth bit
      cnt_nxt = (cnt_eff == POS_LAST) ? '0 : cnt_eff + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_r     <= ST_IDLE;
      sclk_prev_r <= 1'b0;
      cnt_r       <= '0;
      wr_n_r      <= 1'b0;
      sel_r       <= SEL_TEST;
      for (int i = 0; i < NUM_REGS; i++)
        regs_r[i] <= REG_RESET;
    end
    else if (ce)
    begin
      state_r     <= state_nxt;
      sclk_prev_r <= sclk_prev_nxt;
      cnt_r       <= cnt_nxt;
      wr_n_r      <= wr_n_nxt;
      sel_r       <= sel_nxt;
      regs_r      <= regs_nxt;
    end
  end

  assign red_delay_code   = regs_r[SEL_RED];
  assign green_delay_code = regs_r[SEL_GREEN];
  assign blue_delay_code  = regs_r[SEL_BLUE];
  assign test_mode        = regs_r[SEL_TEST][TEST_MODE_BIT];
  assign slice_code       = regs_r[SEL_TEST][PAYLOAD_W-1:SLICE_LSB];

  // ****************************************************
  // scaled views of the settings
  // ****************************************************
  logic [DELAY_NS_W-1:0]        dly_ns_r  [NUM_CH];
  logic [DELAY_NS_W-1:0]        dly_ns_nxt[NUM_CH];
  logic signed [SLICE_MV_W-1:0] slice_mv_r;
  logic signed [SLICE_MV_W-1:0] slice_mv_nxt;
  logic                         green_sl_r;
  logic                         green_sl_nxt;

  // delay in ns and slice level in mV from the codes
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
      dly_ns_nxt[i] = DELAY_NS_W'(regs_r[i+1] * DELAY_STEP_NS);
    slice_mv_nxt = SLICE_MV_W'($signed(slice_code) *
                               SLICE_STEP_MV);
    green_sl_nxt = test_mode;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < NUM_CH; i++)
        dly_ns_r[i] <= '0;
      slice_mv_r <= '0;
      green_sl_r <= 1'b0;
    end
    else if (ce)
    begin
      dly_ns_r   <= dly_ns_nxt;
      slice_mv_r <= slice_mv_nxt;
      green_sl_r <= green_sl_nxt;
    end
  end

  assign red_delay_ns      = dly_ns_r[0];
  assign green_delay_ns    = dly_ns_r[1];
  assign blue_delay_ns     = dly_ns_r[2];
  assign slice_mv          = slice_mv_r;
  assign green_shows_slice = green_sl_r;

  // ****************************************************
  // test outputs: one overlap detector per channel
  // ****************************************************
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_test
    sdc_pair_if pair ();
    // normal: this channel against the next; test: red and blue own in against out, green held low
    always_comb
    begin
      if (test_mode)
      begin
        pair.a = (g == 1) ? 1'b0 : in_s[g];
        pair.b = (g == 1) ? 1'b0 : out_s[g];
      end
      else
      begin
        pair.a = in_s[g];
        pair.b = in_s[(g + 1) % NUM_CH];
      end
    end
    sdc_overlap_det u_det
    (
      .clk  (clk),
      .srst (srst),
      .ce   (ce),
      .pair (pair)
    );
    assign test_pulse_pos[g] = pair.pos;
    assign test_pulse_neg[g] = pair.neg;
  end

endmodule

// *** tb/sdc_monitor.sv ***
`timescale 1ns/1ps
// ****************************************
// pin-level checks of the configuration port
// ****************************************
module sdc_monitor
  import sdc_pkg::*;
(
  input wire logic                         clk,
  input wire logic                         srst,
  input wire logic                         ce,
  input wire logic                         frame_select_n,
  input wire logic                         serial_clock,
  input wire logic [PAYLOAD_W-1:0]         red_delay_code,
  input wire logic [PAYLOAD_W-1:0]         green_delay_code,
  input wire logic [PAYLOAD_W-1:0]         blue_delay_code,
  input wire logic [DELAY_NS_W-1:0]        red_delay_ns,
  input wire logic [DELAY_NS_W-1:0]        green_delay_ns,
  input wire logic [SLICE_W-1:0]           slice_code,
  input wire logic signed [SLICE_MV_W-1:0] slice_mv,
  input wire logic                         test_mode,
  input wire logic                         green_shows_slice,
  input wire logic [NUM_CH-1:0]            test_pulse_pos,
  input wire logic [NUM_CH-1:0]            test_pulse_neg
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // all writable state gathered in one vector
  wire logic [19:0] regs_w = {red_delay_code, green_delay_code,
                              blue_delay_code, slice_code, test_mode};
  // quiet pins long enough for the synchroniser to drain
  sequence frame_idle; frame_select_n [*6]; endsequence
  sequence clock_idle; serial_clock [*6]; endsequence
  sequence mode_held;  test_mode [*8]; endsequence
  red_scale_a : assert property (
    $past(ce) |-> red_delay_ns == {$past(red_delay_code), 1'h0})
    else $error("red delay scale wrong");
  green_scale_a : assert property (
    $past(ce) |-> green_delay_ns == {$past(green_delay_code), 1'h0})
    else $error("green delay scale wrong");
  slice_scale_a : assert property (
    $past(ce) |-> slice_mv == $signed($past(slice_code)) * SLICE_STEP_MV)
    else $error("slice level scale wrong");
  mode_follow_a : assert property (
    $past(ce) |-> green_shows_slice == $past(test_mode))
    else $error("green slice flag not following mode");
  frame_hold_a : assert property (
    frame_idle |=> $stable(regs_w))
    else $error("registers moved with frame high");
  clock_hold_a : assert property (
    clock_idle |=> $stable(regs_w))
    else $error("registers moved without clock fall");
  green_quiet_a : assert property (
    mode_held |-> {test_pulse_pos[1], test_pulse_neg[1]} == 2'h0)
    else $error("green pulse in test mode");
  pulse_excl_a : assert property (
    (test_pulse_pos & test_pulse_neg) == 3'h0)
    else $error("both polarities at once");
endmodule

bind sdc_config_port sdc_monitor u_mon
(
  .clk, .srst, .ce, .frame_select_n, .serial_clock, .red_delay_code,
  .green_delay_code, .blue_delay_code, .red_delay_ns, .green_delay_ns,
  .slice_code, .slice_mv, .test_mode, .green_shows_slice,
  .test_pulse_pos, .test_pulse_neg
);

// *** tb/sdc_host.sv ***
`timescale 1ns/1ps
// ****************************************
// host controller on the serial pins
// ****************************************
module sdc_host
(
  input  wire logic clk,
  output logic      frame_select_n,
  output logic      serial_clock,
  output logic      serial_data
);
  localparam int HALF = 16; // 80 ns half period of the link clock
  // pins idle: frame off, clock parked high
  initial
  begin
    frame_select_n = 1'h1;
    serial_clock   = 1'h1;
    serial_data    = 1'h1;
  end
  task automatic hw(int n);
    repeat (n) @(posedge clk);
  endtask
  // one frame carrying the n low bits of w, msb first
  task automatic send(logic [15:0] w, int n);
    frame_select_n <= 1'h0;
    hw(HALF);
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_data  <= w[i];
      hw(HALF);
      serial_clock <= 1'h0;
      hw(HALF);
      serial_clock <= 1'h1;
    end
    serial_data    <= ~serial_data; // released line does not keep value
    hw(HALF);
    frame_select_n <= 1'h1;
    hw(HALF);
  endtask
  // clock pulses with frame held off
  task automatic stray(int n);
    repeat (n)
    begin
      serial_clock <= 1'h0;
      hw(HALF);
      serial_clock <= 1'h1;
      hw(HALF);
    end
  endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("ERROR at %0t got %h expected %h", $time, got, exp); \
    end \
  end
module tb
  import sdc_pkg::*;
;
  logic                         clk = 1'h0;
  logic                         srst = 1'h1;
  logic                         frame_select_n, serial_clock, serial_data;
  logic [NUM_CH-1:0]            slice_in = 3'h0;
  logic [NUM_CH-1:0]            slice_out = 3'h0;
  logic [PAYLOAD_W-1:0]         red_delay_code, green_delay_code;
  logic [PAYLOAD_W-1:0]         blue_delay_code;
  logic [DELAY_NS_W-1:0]        red_delay_ns, green_delay_ns, blue_delay_ns;
  logic [SLICE_W-1:0]           slice_code;
  logic signed [SLICE_MV_W-1:0] slice_mv;
  logic                         test_mode, green_shows_slice;
  logic [NUM_CH-1:0]            test_pulse_pos, test_pulse_neg;
  int                           mismatches = 0;
  int                           samples_checked = 0;
  int                           cycles = 0;
  // ****************************************
  // design, host and clock
  // ****************************************
  sdc_config_port DUT (.clk, .srst, .ce(1'h1), .frame_select_n,
    .serial_clock, .serial_data, .slice_in, .slice_out, .red_delay_code,
    .green_delay_code, .blue_delay_code, .red_delay_ns, .green_delay_ns,
    .blue_delay_ns, .slice_code, .slice_mv, .test_mode, .green_shows_slice,
    .test_pulse_pos, .test_pulse_neg);
  sdc_host u_host (.clk, .frame_select_n, .serial_clock, .serial_data);
  always #2.5 clk = ~clk;
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      test_done();
    end
  end
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    `CHK({red_delay_code, green_delay_code, blue_delay_code}, 15'h0)
    `CHK({slice_code, test_mode, test_pulse_pos}, 8'h0)
  endtask
  // one word to each register, test word with most negative slice
  task automatic t_regs();
    u_host.send(16'h35, 8);
    u_host.send(16'h5F, 8);
    u_host.send(16'h61, 8);
    u_host.send(16'h10, 8);
    `CHK(red_delay_code, 5'h15)
    `CHK(red_delay_ns, 6'h2A)
    `CHK(green_delay_ns, 6'h3E)
    `CHK(blue_delay_ns, 6'h02)
    `CHK(blue_delay_code, 5'h01)
    `CHK(slice_mv, 10'h270)
  endtask
  // two words in one frame, then a short word and a fresh frame
  task automatic t_burst();
    u_host.send(16'h472C, 16);
    `CHK({green_delay_code, red_delay_code}, 10'h0EC)
    u_host.send(16'h06, 5);
    `CHK(red_delay_code, 5'h12)
    u_host.send(16'h3F, 8);
    `CHK(red_delay_code, 5'h1F)
    u_host.stray(10);
    `CHK({red_delay_code, green_delay_code}, 10'h3E7)
  endtask
  // overlap pulses in test mode, then in normal mode both orders
  task automatic t_test();
    u_host.send(16'h0F, 8);
    `CHK({slice_code, test_mode, green_shows_slice}, 6'h1F)
    `CHK(slice_mv, 10'h15E)
    slice_in <= 3'h3;
    cyc(8);
    slice_in  <= 3'h7;
    slice_out <= 3'h7;
    cyc(8);
    `CHK({test_pulse_pos, test_pulse_neg}, 6'h08)
    slice_in  <= 3'h0;
    slice_out <= 3'h0;
    u_host.send(16'h0E, 8);
    slice_in <= 3'h1;
    cyc(8);
    slice_in <= 3'h3;
    cyc(8);
    `CHK({test_pulse_pos, test_pulse_neg}, 6'h08)
    slice_in <= 3'h2;
    cyc(8);
    slice_in <= 3'h3;
    cyc(8);
    `CHK({test_pulse_pos, test_pulse_neg}, 6'h01)
    slice_in <= 3'h0;
  endtask
  // main sequence
  initial
  begin
    cyc(4);
    srst <= 1'h0;
    cyc(3);
    t_reset();
    t_regs();
    t_burst();
    t_test();
    cyc(8);
    test_done();
  end
endmodule
